// *** include/wrap_coord_consts.vh ***
/*
 Constants of the wrap-around coordinate block: register byte
 addresses, field positions, reset values and divider figures.
 Assumes a 32-bit AHB-Lite bus with one word per register.
*/
`ifndef WRAP_COORD_CONSTS_VH
`define WRAP_COORD_CONSTS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define A_CTRL 8'h00
`define A_RANGE 8'h04
`define A_RATIO 8'h08
`define A_OFFSET 8'h0c
`define A_GEAR_A 8'h10
`define A_GEAR_B 8'h14
`define A_CMD 8'h18
`define A_STATUS 8'h1c
`define A_IRQ_STAT 8'h20
`define A_IRQ_MASK 8'h24
`define A_POS 8'h28
`define A_LOWER 8'h2c
`define A_UPPER 8'h30

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_MANUAL 0
`define CTRL_WRAP 1
`define CTRL_SPAN 2
`define CMD_CFG 0
`define CMD_PWR 1
`define CMD_PRESET 2
`define CMD_ALM_CLR 3
`define IRQ_INFO 0
`define IRQ_ALARM 1
`define IRQ_DONE 2
`define IRQ_WRAP 3

// ------------------------------------------------------------
// Reset values and arithmetic figures
// ------------------------------------------------------------
`define RANGE_RST 16'h0064
`define RATIO_RST 14'h1388
`define RATIO_MAX 14'h2710
`define OFFSET_RST 30'h0
`define GEAR_RST 16'h0001
`define SPAN_FULL 16'h4650
`define SPAN_HALF 16'h2328
`define STEP_SCALE 16'h0064
`define RATIO_DIV 16'h2710

`endif

// *** rtl/wrap_divider.v ***
/*
 Unsigned restoring divider, one quotient bit per clock.
 Assumes start is a one-cycle pulse and inputs are held by the caller
 only in the start cycle.
*/
`timescale 1ns/10ps
module wrap_divider #(
	parameter W = 56,
	parameter CW = 6
) (
	// Clock and reset.
	input wire clock,
	input wire rst_n,
	// Operands.
	input wire start,
	input wire [W-1:0] dividend,
	input wire [W-1:0] divisor,
	// Results.
	output reg done,
	output reg [W-1:0] quotient,
	output reg [W-1:0] remainder
);
	localparam [CW-1:0] STEPS = W;
	localparam [CW-1:0] ONE = 1;

	reg [CW-1:0] count;
	reg run;
	reg [W-1:0] div_q;

	// Trial subtraction; bit W set means the divisor did not fit.
	wire [W:0] trial = {remainder, quotient[W-1]} - {1'b0, div_q};

	// ------------------------------------------------------------
	// Iteration
	// ------------------------------------------------------------
	// A zero divisor yields an all-ones quotient and the dividend
	// as remainder, which the caller reads as a failed check.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
			run <= 1'b0;
			count <= {CW{1'b0}};
			quotient <= {W{1'b0}};
			remainder <= {W{1'b0}};
			div_q <= {W{1'b0}};
		end else if (start) begin
			done <= 1'b0;
			run <= 1'b1;
			count <= STEPS;
			quotient <= dividend;
			remainder <= {W{1'b0}};
			div_q <= divisor;
		end else if (run) begin
			if (!trial[W]) begin
				remainder <= trial[W-1:0];
				quotient <= {quotient[W-2:0], 1'b1};
			end else begin
				remainder <= {remainder[W-2:0], quotient[W-1]};
				quotient <= {quotient[W-2:0], 1'b0};
			end
			count <= count - ONE;
			if (count == ONE) begin
				run <= 1'b0;
				done <= 1'b1;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule

// *** rtl/wrap_coordinate_logic.v ***
/*
 Wrap-around coordinate logic: AHB-Lite register file, range checks,
 window placement, wrapped command position and interrupt.
 Assumes step_pulse and step_dir come from logic on the same clock and
 that the bus master issues single word transfers only.
*/
`timescale 1ns/10ps
`include "wrap_coord_consts.vh"
module wrap_coordinate_logic #(
	parameter DW = 56
) (
	// Clock and reset.
	input wire clock,
	input wire rst_n,
	// AHB-Lite slave port.
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	// Motor step commands.
	input wire step_pulse,
	input wire step_dir,
	// Coordinate and error state.
	output reg [31:0] cmd_pos,
	output reg wrap_active,
	output reg wrap_info,
	output reg wrap_alarm,
	output reg irq
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_C1 = 3'h1;
	localparam [2:0] S_C2 = 3'h2;
	localparam [2:0] S_C3 = 3'h3;
	localparam [2:0] S_FIN = 3'h4;
	localparam signed [47:0] P_ZERO = 48'sh0;
	localparam signed [47:0] P_ONE = 48'sh1;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	reg manual;
	reg wrap_en;
	reg span_half;
	reg [15:0] range;
	reg [13:0] ratio;
	reg [29:0] offset;
	reg [15:0] gear_a;
	reg [15:0] gear_b;
	reg [3:0] stat;
	reg [3:0] mask;
	reg wr_pend;
	reg [7:0] wr_addr;
	reg [31:0] rd_mux;
	reg [2:0] state;
	reg dirty;
	reg div_start;
	reg [DW-1:0] div_a;
	reg [DW-1:0] div_b;
	reg c1_ok;
	reg c2_ok;
	reg signed [47:0] steps;
	reg signed [47:0] share;
	reg signed [47:0] lower;
	reg signed [47:0] upper;
	reg signed [47:0] pos;
	reg [13:0] ratio_in;

	wire div_done;
	wire [DW-1:0] quo;
	wire [DW-1:0] rem;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// A transfer is taken when selected, the bus is ready and the
	// master drives NONSEQ or SEQ.
	wire take = hsel & hready & htrans[1];
	wire we_ctrl = wr_pend & (wr_addr == `A_CTRL);
	wire we_range = wr_pend & (wr_addr == `A_RANGE);
	wire we_ratio = wr_pend & (wr_addr == `A_RATIO);
	wire we_off = wr_pend & (wr_addr == `A_OFFSET);
	wire we_ga = wr_pend & (wr_addr == `A_GEAR_A);
	wire we_gb = wr_pend & (wr_addr == `A_GEAR_B);
	wire we_cmd = wr_pend & (wr_addr == `A_CMD);
	wire we_istat = wr_pend & (wr_addr == `A_IRQ_STAT);
	wire we_mask = wr_pend & (wr_addr == `A_IRQ_MASK);

	wire cmd_cfg = we_cmd & hwdata[`CMD_CFG];
	wire cmd_pwr = we_cmd & hwdata[`CMD_PWR];
	wire cmd_preset = we_cmd & hwdata[`CMD_PRESET];
	wire cmd_alm_clr = we_cmd & hwdata[`CMD_ALM_CLR];

	// Any change to the settings, or a restart, reruns the checks.
	wire param_we = we_ctrl | we_range | we_ratio | we_off | we_ga |
		we_gb | cmd_cfg | cmd_pwr;

	// ------------------------------------------------------------
	// Derived state
	// ------------------------------------------------------------
	wire busy = (state != S_IDLE) | dirty;
	wire active = manual & wrap_en;
	wire home_ok = (lower <= P_ZERO) & (upper >= P_ZERO);
	wire ok_all = c1_ok & c2_ok & home_ok;
	wire next_info = busy ? wrap_info : (active & ~ok_all);
	wire next_alarm = ((cmd_cfg | cmd_pwr) & wrap_info) |
		(wrap_alarm & ~cmd_alm_clr);
	wire signed [47:0] off_x = {{18{offset[29]}}, offset};
	wire [DW-1:0] range_w = {{(DW-16){1'b0}}, range};
	wire [DW-1:0] gb_w = {{(DW-16){1'b0}}, gear_b};
	wire [DW-1:0] scale_w = {{(DW-16){1'b0}}, `STEP_SCALE};
	wire [DW-1:0] ratio_w = {{(DW-14){1'b0}}, ratio};
	wire [DW-1:0] ratio_prod = quo * ratio_w;
	wire fwd_wrap = wrap_active & (pos >= upper);
	wire rev_wrap = wrap_active & (pos <= lower);
	wire wrap_evt = step_pulse & (step_dir ? fwd_wrap : rev_wrap);
	wire [3:0] stat_set = {wrap_evt, state == S_FIN,
		next_alarm & ~wrap_alarm, next_info & ~wrap_info};

	// Offset ratio writes above full scale are held at full scale.
	always @* begin
		if (hwdata[31:14] != 18'h0 || hwdata[13:0] > `RATIO_MAX) begin
			ratio_in = `RATIO_MAX;
		end else begin
			ratio_in = hwdata[13:0];
		end
	end

	// Read data multiplexer on the address phase.
	always @* begin
		case (haddr[7:0])
		`A_CTRL: rd_mux = {29'h0, span_half, wrap_en, manual};
		`A_RANGE: rd_mux = {16'h0, range};
		`A_RATIO: rd_mux = {18'h0, ratio};
		`A_OFFSET: rd_mux = {{2{offset[29]}}, offset};
		`A_GEAR_A: rd_mux = {16'h0, gear_a};
		`A_GEAR_B: rd_mux = {16'h0, gear_b};
		`A_STATUS: rd_mux = {26'h0, home_ok, c2_ok, c1_ok, busy,
			wrap_alarm, wrap_info};
		`A_IRQ_STAT: rd_mux = {28'h0, stat};
		`A_IRQ_MASK: rd_mux = {28'h0, mask};
		`A_POS: rd_mux = pos[31:0];
		`A_LOWER: rd_mux = lower[31:0];
		`A_UPPER: rd_mux = upper[31:0];
		default: rd_mux = 32'h0;
		endcase
	end

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	// Zero wait states: reads are registered in the address phase,
	// writes land at the end of the data phase. Response is OKAY.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h0;
		end else begin
			wr_pend <= take & hwrite;
			if (take) begin
				wr_addr <= haddr[7:0];
			end
			if (take & ~hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Setting registers written by software.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			manual <= 1'b0;
			wrap_en <= 1'b1;
			span_half <= 1'b0;
			range <= `RANGE_RST;
			ratio <= `RATIO_RST;
			offset <= `OFFSET_RST;
			gear_a <= `GEAR_RST;
			gear_b <= `GEAR_RST;
			mask <= 4'h0;
		end else begin
			if (we_ctrl) begin
				manual <= hwdata[`CTRL_MANUAL];
				wrap_en <= hwdata[`CTRL_WRAP];
				span_half <= hwdata[`CTRL_SPAN];
			end
			if (we_range) begin
				range <= hwdata[15:0];
			end
			if (we_ratio) begin
				ratio <= ratio_in;
			end
			if (we_off) begin
				offset <= hwdata[29:0];
			end
			// Gear terms of zero are refused to keep the divisor sane.
			if (we_ga && hwdata[15:0] != 16'h0) begin
				gear_a <= hwdata[15:0];
			end
			if (we_gb && hwdata[15:0] != 16'h0) begin
				gear_b <= hwdata[15:0];
			end
			if (we_mask) begin
				mask <= hwdata[3:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Range checks and window placement
	// ------------------------------------------------------------
	// Three divisions in turn: span by range, range in steps by gear A,
	// and the ratio share of the window length.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			dirty <= 1'b1;
			div_start <= 1'b0;
			div_a <= {DW{1'b0}};
			div_b <= {DW{1'b0}};
			c1_ok <= 1'b0;
			c2_ok <= 1'b0;
			steps <= P_ZERO;
			share <= P_ZERO;
			lower <= P_ZERO;
			upper <= P_ZERO;
		end else begin
			div_start <= 1'b0;
			dirty <= param_we | (dirty & (state != S_IDLE));
			case (state)
			S_IDLE: begin
				if (dirty) begin
					div_a <= {{(DW-16){1'b0}},
						span_half ? `SPAN_HALF : `SPAN_FULL};
					div_b <= range_w;
					div_start <= 1'b1;
					state <= S_C1;
				end
			end
			S_C1: begin
				if (div_done) begin
					c1_ok <= (rem == {DW{1'b0}}) & (range != 16'h0);
					div_a <= range_w * gb_w * scale_w;
					div_b <= {{(DW-16){1'b0}}, gear_a};
					div_start <= 1'b1;
					state <= S_C2;
				end
			end
			S_C2: begin
				if (div_done) begin
					c2_ok <= (rem == {DW{1'b0}});
					steps <= quo[47:0];
					div_a <= ratio_prod;
					div_b <= {{(DW-16){1'b0}}, `RATIO_DIV};
					div_start <= 1'b1;
					state <= S_C3;
				end
			end
			S_C3: begin
				if (div_done) begin
					share <= quo[47:0];
					state <= S_FIN;
				end
			end
			S_FIN: begin
				// Home is step zero; the window starts share steps below the offset.
				lower <= off_x - share;
				upper <= off_x - share + steps - P_ONE;
				state <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	wrap_divider #(
		.W(DW),
		.CW(6)
	) u_div (
		.clock(clock),
		.rst_n(rst_n),
		.start(div_start),
		.dividend(div_a),
		.divisor(div_b),
		.done(div_done),
		.quotient(quo),
		.remainder(rem)
	);

	// ------------------------------------------------------------
	// Error information and alarm
	// ------------------------------------------------------------
	// Info and active state follow only settled results, so a check
	// in progress never flickers the outputs. The alarm set wins over
	// a clear in the same cycle.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wrap_info <= 1'b0;
			wrap_active <= 1'b0;
			wrap_alarm <= 1'b0;
		end else begin
			wrap_info <= next_info;
			if (!busy) begin
				wrap_active <= active & ok_all;
			end
			wrap_alarm <= next_alarm;
		end
	end

	// ------------------------------------------------------------
	// Command position
	// ------------------------------------------------------------
	// Steps fold at the window ends while wrapping runs; otherwise the
	// count runs free. A window change does not move the count, so
	// software presets or homes after changing enable or range.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pos <= P_ZERO;
			cmd_pos <= 32'h0;
		end else begin
			cmd_pos <= pos[31:0];
			if (cmd_preset | cmd_pwr) begin
				pos <= P_ZERO;
			end else if (step_pulse) begin
				if (step_dir) begin
					if (fwd_wrap) begin
						pos <= lower;
					end else begin
						pos <= pos + P_ONE;
					end
				end else begin
					if (rev_wrap) begin
						pos <= upper;
					end else begin
						pos <= pos - P_ONE;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	// Sticky status, cleared by writing one; a new event in the same
	// cycle as its clear stays set.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stat <= 4'h0;
			irq <= 1'b0;
		end else begin
			if (we_istat) begin
				stat <= (stat & ~hwdata[3:0]) | stat_set;
			end else begin
				stat <= stat | stat_set;
			end
			irq <= |(stat & mask);
		end
	end
endmodule

// *** tb/wrap_coordinate_logic_props.sv ***
/*
 Checker for the wrap-around coordinate block, bound to its top module.
 Assumes the bench keeps steps apart from preset commands.
*/
`timescale 1ns/10ps
module wrap_coordinate_logic_props #(
	parameter DW = 56
) (
	// Clock and reset.
	input wire clock,
	input wire rst_n,
	// Bus side.
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Step and coordinate side.
	input wire step_pulse,
	input wire step_dir,
	input wire [31:0] cmd_pos,
	input wire wrap_active,
	input wire wrap_info,
	input wire wrap_alarm,
	input wire irq
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A single step with three quiet cycles before and after it.
	sequence lone(d, a);
		!step_pulse[*3] ##1 (step_pulse && step_dir == d &&
		wrap_active == a) ##1 !step_pulse[*3];
	endsequence
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	AST_INFO_STOPS_WRAP: assert property (wrap_info |-> !wrap_active)
		else $error("wrapping runs with setting error");
	AST_FWD_PLAIN: assert property (lone(1'b1, 1'b0) |->
		cmd_pos == $past(cmd_pos, 4) + 32'h1)
		else $error("forward step did not add one");
	AST_REV_PLAIN: assert property (lone(1'b0, 1'b0) |->
		cmd_pos == $past(cmd_pos, 4) - 32'h1)
		else $error("reverse step did not take one");
	AST_FWD_FOLD: assert property (lone(1'b1, 1'b1) |->
		cmd_pos == $past(cmd_pos, 4) + 32'h1 ||
		$signed(cmd_pos) < $signed($past(cmd_pos, 4)))
		else $error("forward step moved wrongly");
	AST_REV_FOLD: assert property (lone(1'b0, 1'b1) |->
		cmd_pos == $past(cmd_pos, 4) - 32'h1 ||
		$signed(cmd_pos) > $signed($past(cmd_pos, 4)))
		else $error("reverse step moved wrongly");
	AST_ALARM_CAUSE: assert property ($rose(wrap_alarm) |->
		$past(wrap_info))
		else $error("alarm rose without setting error");
	AST_ALARM_HOLD: assert property (wrap_alarm && !$past(htrans[1]) |=>
		wrap_alarm)
		else $error("alarm dropped without a bus write");
	// Main scenarios.
	cover property ($rose(wrap_alarm));
	cover property ($rose(irq));
	cover property (lone(1'b1, 1'b1));
endmodule

bind wrap_coordinate_logic wrap_coordinate_logic_props #(.DW(DW)) u_props (
	.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .step_pulse(step_pulse), .step_dir(step_dir),
	.cmd_pos(cmd_pos), .wrap_active(wrap_active), .wrap_info(wrap_info),
	.wrap_alarm(wrap_alarm), .irq(irq));

// *** tb/wrap_coordinate_logic_bench.sv ***
/*
 Self-checking bench for the wrap-around coordinate block.
 Assumes one AHB-Lite slave whose ready output is the bus ready.
*/
`timescale 1ns/10ps
`include "wrap_coord_consts.vh"
module wrap_coordinate_logic_bench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic step_pulse = 1'b0;
	logic step_dir = 1'b0;
	wire hready, hresp, wrap_active, wrap_info, wrap_alarm, irq;
	wire [31:0] hrdata, cmd_pos;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	wrap_coordinate_logic u_wrap_coordinate_logic (.clock(clock),
		.rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.step_pulse(step_pulse), .step_dir(step_dir), .cmd_pos(cmd_pos),
		.wrap_active(wrap_active), .wrap_info(wrap_info),
		.wrap_alarm(wrap_alarm), .irq(irq));
	// Clock of 4 ns and a cut-off for a hung run.
	always #2 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task report_and_stop;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task pause(input int n);
		repeat (n) @(posedge clock);
	endtask
	// One single word transfer; waits on ready in both phases.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		chk("ready", 32'h1, {31'h0, hready});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk($sformatf("register %h", a), e, x);
	endtask
	// Polls until the range checks have finished.
	task settle;
		logic [31:0] d;
		int n;
		n = 0;
		d = 32'h4;
		pause(4);
		while (d[2] !== 1'b0 && n < 400) begin
			bus(1'b0, `A_STATUS, 32'h0, d);
			n++;
		end
		chk("busy", 32'h0, {31'h0, d[2]});
	endtask
	task step(input logic d, input int n);
		repeat (n) begin
			step_pulse <= 1'b1;
			step_dir <= d;
			@(posedge clock);
		end
		step_pulse <= 1'b0;
		pause(4);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		settle;
		rchk(`A_CTRL, 32'h2);
		rchk(`A_RANGE, 32'h64);
		rchk(`A_RATIO, 32'h1388);
		rchk(`A_OFFSET, 32'h0);
		rchk(8'h40, 32'h0);
		chk("info", 32'h0, {31'h0, wrap_info});
	endtask
	task t_window;
		wr(`A_CTRL, 32'h3);
		wr(`A_RANGE, 32'ha);
		settle;
		rchk(`A_STATUS, 32'h38);
		rchk(`A_LOWER, 32'hfffffe0c);
		rchk(`A_UPPER, 32'h1f3);
		wr(`A_CMD, 32'h4);
		pause(3);
		chk("pos", 32'h0, cmd_pos);
		chk("active", 32'h1, {31'h0, wrap_active});
		step(1'b1, 499);
		chk("pos", 32'h1f3, cmd_pos);
		step(1'b1, 1);
		chk("pos", 32'hfffffe0c, cmd_pos);
		step(1'b0, 1);
		chk("pos", 32'h1f3, cmd_pos);
		rchk(`A_POS, 32'h1f3);
		rchk(`A_IRQ_STAT, 32'hc);
		wr(`A_IRQ_STAT, 32'hc);
		rchk(`A_IRQ_STAT, 32'h0);
	endtask
	task t_offset;
		wr(`A_RATIO, 32'h4e20);
		rchk(`A_RATIO, 32'h2710);
		wr(`A_OFFSET, 32'h3e9);
		settle;
		rchk(`A_LOWER, 32'h1);
		chk("info", 32'h1, {31'h0, wrap_info});
		chk("active", 32'h0, {31'h0, wrap_active});
		step(1'b1, 1);
		chk("pos", 32'h1f4, cmd_pos);
		step(1'b0, 1);
		chk("pos", 32'h1f3, cmd_pos);
		wr(`A_OFFSET, 32'h3ffffc18);
		rchk(`A_OFFSET, 32'hfffffc18);
		wr(`A_RATIO, 32'h0);
		wr(`A_OFFSET, 32'h3ffffe0c);
		settle;
		rchk(`A_LOWER, 32'hfffffe0c);
		chk("info", 32'h0, {31'h0, wrap_info});
	endtask
	task t_checks;
		wr(`A_RATIO, 32'h1388);
		wr(`A_OFFSET, 32'h0);
		wr(`A_RANGE, 32'h7);
		settle;
		rchk(`A_STATUS, 32'h31);
		wr(`A_RANGE, 32'ha);
		wr(`A_GEAR_A, 32'h3);
		settle;
		rchk(`A_STATUS, 32'h29);
		wr(`A_GEAR_B, 32'h3);
		settle;
		rchk(`A_STATUS, 32'h38);
		wr(`A_GEAR_B, 32'h1);
		wr(`A_GEAR_A, 32'h1);
		wr(`A_CTRL, 32'h7);
		wr(`A_RANGE, 32'h4650);
		settle;
		rchk(`A_STATUS, 32'h31);
		wr(`A_CTRL, 32'h3);
		settle;
		rchk(`A_STATUS, 32'h38);
	endtask
	task t_alarm_irq;
		wr(`A_IRQ_STAT, 32'hf);
		wr(`A_IRQ_MASK, 32'h1);
		wr(`A_RANGE, 32'h7);
		settle;
		pause(3);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`A_IRQ_MASK, 32'h0);
		pause(3);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`A_IRQ_MASK, 32'h1);
		wr(`A_IRQ_STAT, 32'h1);
		pause(3);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`A_CMD, 32'h1);
		pause(3);
		chk("alarm", 32'h1, {31'h0, wrap_alarm});
		rchk(`A_IRQ_STAT, 32'h6);
		settle;
		wr(`A_CMD, 32'h8);
		pause(3);
		chk("alarm", 32'h0, {31'h0, wrap_alarm});
		wr(`A_CMD, 32'h2);
		settle;
		chk("alarm", 32'h1, {31'h0, wrap_alarm});
		chk("pos", 32'h0, cmd_pos);
		wr(`A_CMD, 32'h8);
		wr(`A_CTRL, 32'h1);
		settle;
		chk("info", 32'h0, {31'h0, wrap_info});
		wr(`A_CMD, 32'h1);
		pause(3);
		chk("alarm", 32'h0, {31'h0, wrap_alarm});
		wr(`A_CTRL, 32'h2);
		settle;
		chk("active", 32'h0, {31'h0, wrap_active});
	endtask
	// Reset for three cycles, then every scenario in turn.
	initial begin
		pause(3);
		rst_n <= 1'b1;
		pause(1);
		t_reset;
		t_window;
		t_offset;
		t_checks;
		t_alarm_irq;
		report_and_stop;
	end
endmodule
